/* File: inc/loader_regs.svh */
// Constants for the code-memory loader: widths and sizes.
// Assumes inclusion by bare name from the package and modules.
`ifndef LOADER_REGS_SVH
`define LOADER_REGS_SVH
`define LOADER_WORD_WIDTH   32
`define LOADER_ADDR_WIDTH   12
`define LOADER_CODE_DEPTH   4096
`define LOADER_ADDR_RESET   12'h000
`define LOADER_BUF_DEPTH    2
`endif

/* File: inc/loader_pkg.sv */
// Types shared by the loader and its buffer.
// Assumes loader_regs.svh is on the include path.
`include "loader_regs.svh"
package loader_pkg;
  typedef logic [`LOADER_WORD_WIDTH-1:0] word_t;
  typedef logic [`LOADER_ADDR_WIDTH-1:0] addr_t;
  // A fetched word paired with the code-memory address it belongs to
  typedef struct packed {
    addr_t addr;
    word_t data;
  } code_beat_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DRAIN = 2'b11,
    ST_DONE = 2'b10
  } load_state_e;
endpackage : loader_pkg

/* File: verilog/beat_buffer.sv */
// Two-entry valid/ready buffer for address/word beats.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "loader_regs.svh"
module beat_buffer
  import loader_pkg::*;
#(
  parameter int DEPTH = `LOADER_BUF_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire code_beat_s in_beat_i,
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output code_beat_s      out_beat_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  code_beat_s    mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  wire           push = in_valid_i && in_ready_o;
  wire           pop  = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_beat_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_beat_i;
  end
endmodule : beat_buffer
`default_nettype wire

/* File: verilog/code_memory_rom_loader.sv */
// Loader that fills the sequencer code memory from an external ROM.
// Assumes the ROM and user logic run on the loader clock; strobes arrive
// from pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "loader_regs.svh"
module code_memory_rom_loader
  import loader_pkg::*;
#(
  parameter int CODE_DEPTH = `LOADER_CODE_DEPTH
) (
  input  wire logic  CORE_CLK_I,
  input  wire logic  RST_B_I,
  input  wire logic  LOADER_LOAD_ACTIVE_I,
  input  wire logic  LOADER_WORD_READY_I,
  input  wire word_t LOADER_ROM_WORD_IN_I,
  output logic       LOADER_LOAD_BUSY_O,
  output logic       LOADER_ROM_READ_ENABLE_O,
  output addr_t      LOADER_ROM_ADDR_O,
  output logic       CODE_WR_EN_O,
  output addr_t      CODE_WR_ADDR_O,
  output word_t      CODE_WR_DATA_O,
  input  wire logic  CODE_WR_READY_I
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] active_sync;
  logic [2:0] ready_sync;
  logic       active_lvl;
  logic       ready_lvl;
  word_t      word_q1;
  word_t      word_q2;

  // A change counts only once the last two stages agree, so a single
  // unsettled sample can never start a load or count a word
  wire active_agree = (active_sync[1] == active_sync[2]);
  wire ready_agree  = (ready_sync[1] == ready_sync[2]);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      active_sync <= 3'h0;
      active_lvl  <= 1'b0;
    end else begin
      active_sync <= {active_sync[1:0], LOADER_LOAD_ACTIVE_I};
      if (active_agree) active_lvl <= active_sync[2];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      ready_sync <= 3'h0;
      ready_lvl  <= 1'b0;
    end else begin
      ready_sync <= {ready_sync[1:0], LOADER_WORD_READY_I};
      if (ready_agree) ready_lvl <= ready_sync[2];
    end
  end

  // Data follows the strobe delay so it is stable when ready is seen
  always_ff @(posedge CORE_CLK_I) begin
    word_q1 <= LOADER_ROM_WORD_IN_I;
    word_q2 <= word_q1;
  end

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  // One step of the word address, shared by the counter and the pin
  // register so the two step alike; the pin resets from next_state and the counter from state, so they differ for a cycle around idle
  function automatic addr_t step_addr(input addr_t a);
    step_addr = a + addr_t'(1);
  endfunction : step_addr

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  load_state_e state;
  load_state_e next_state;
  logic        ready_prev;
  addr_t       rom_addr;
  logic        last_taken;
  logic        buf_in_ready;
  logic        buf_out_valid;
  code_beat_s  buf_out;
  code_beat_s  beat_in;

  wire  last_addr  = (rom_addr == addr_t'(CODE_DEPTH - 1));
  // Word-ready rising edge while loading and buffer has room. An edge that
  // finds the buffer full is ignored and the address holds, so the host
  // fetches and offers the same word again.
  wire  ready_rise = ready_lvl && !ready_prev;
  wire  take_word  = (state == ST_LOAD) && ready_rise && buf_in_ready;
  wire  fill_done  = (state == ST_DRAIN) && !buf_out_valid;

  assign beat_in.addr = rom_addr;
  assign beat_in.data = word_q2;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (active_lvl) next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (take_word && last_addr) next_state = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (fill_done) next_state = ST_DONE;
      end
      ST_DONE: begin
        // Rearm only after the host drops the load request
        if (!active_lvl) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Counter value for the next cycle; idle parks it at the first word
  wire addr_t next_rom_addr = (state == ST_IDLE) ? `LOADER_ADDR_RESET
                              : (take_word && !last_addr) ? step_addr(rom_addr)
                              : rom_addr;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      ready_prev <= 1'b0;
      last_taken <= 1'b0;
    end else begin
      ready_prev <= ready_lvl;
      last_taken <= take_word && last_addr;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      rom_addr <= `LOADER_ADDR_RESET;
    end else begin
      rom_addr <= next_rom_addr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Busy is raised from load start and held until the last word lands,
  // so the PHY soft reset can be gated on it safely.
  wire        next_busy    = (next_state == ST_LOAD) || (next_state == ST_DRAIN);
  wire        next_rden    = (next_state == ST_LOAD) && !last_taken;
  // The pin returns to zero as soon as the session closes, but a load that
  // starts after a single idle cycle first drives the counter's stale last address
  wire addr_t next_rom_pin = (next_state == ST_IDLE) ? `LOADER_ADDR_RESET
                             : (take_word && !last_addr) ? step_addr(rom_addr)
                             : rom_addr;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      LOADER_LOAD_BUSY_O <= 1'b0;
    end else begin
      LOADER_LOAD_BUSY_O <= next_busy;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      LOADER_ROM_READ_ENABLE_O <= 1'b0;
    end else begin
      LOADER_ROM_READ_ENABLE_O <= next_rden;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      LOADER_ROM_ADDR_O <= `LOADER_ADDR_RESET;
    end else begin
      LOADER_ROM_ADDR_O <= next_rom_pin;
    end
  end

  // ----------------------------------------------------------------
  // Code-memory write path
  // ----------------------------------------------------------------
  // The buffer absorbs a stall by the code memory; the loader clock is
  // also the memory write clock, so no crossing is needed.
  beat_buffer #(
    .DEPTH(`LOADER_BUF_DEPTH)
  ) u_buf (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .in_valid_i (take_word),
    .in_ready_o (buf_in_ready),
    .in_beat_i  (beat_in),
    .out_valid_o(buf_out_valid),
    .out_ready_i(CODE_WR_READY_I),
    .out_beat_o (buf_out)
  );

  // Write strobe stays combinational so a write lands in the same cycle
  // the memory signals ready; address and data come from buffer flops
  wire  code_accept = buf_out_valid && CODE_WR_READY_I;

  assign CODE_WR_EN_O   = code_accept;
  assign CODE_WR_ADDR_O = buf_out.addr;
  assign CODE_WR_DATA_O = buf_out.data;
endmodule : code_memory_rom_loader
`default_nettype wire

/* File: testbench/code_memory_rom_loader_assertions.sv */
// Port checks for the loader.
// Assumes it is bound into code_memory_rom_loader.
`timescale 1ns/1ps
`default_nettype none
`include "loader_regs.svh"
module code_memory_rom_loader_assertions
  import loader_pkg::*;
#(parameter int CODE_DEPTH = `LOADER_CODE_DEPTH) (
  input wire logic  CORE_CLK_I,
  input wire logic  RST_B_I,
  input wire logic  LOADER_LOAD_BUSY_O,
  input wire logic  LOADER_ROM_READ_ENABLE_O,
  input wire addr_t LOADER_ROM_ADDR_O,
  input wire logic  CODE_WR_EN_O,
  input wire addr_t CODE_WR_ADDR_O,
  input wire logic  CODE_WR_READY_I
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  property p_wr_ready; CODE_WR_EN_O |-> CODE_WR_READY_I; endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write while not ready");
  property p_wr_busy; CODE_WR_EN_O |-> LOADER_LOAD_BUSY_O; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write while idle");
  property p_done; $fell(LOADER_LOAD_BUSY_O) |-> !LOADER_ROM_READ_ENABLE_O; endproperty
  a_done: assert property (p_done) else $error("read enable after done");
  property p_rden; LOADER_ROM_READ_ENABLE_O |-> LOADER_LOAD_BUSY_O; endproperty
  a_rden: assert property (p_rden) else $error("read enable while idle");
  property p_step;
    $changed(LOADER_ROM_ADDR_O) |-> LOADER_ROM_ADDR_O == $past(LOADER_ROM_ADDR_O) + 12'h001
      || LOADER_ROM_ADDR_O == 12'h000;
  endproperty
  a_step: assert property (p_step) else $error("address skipped");
  property p_start; $rose(LOADER_LOAD_BUSY_O) |-> LOADER_ROM_ADDR_O == 12'h000; endproperty
  a_start: assert property (p_start) else $error("load not at zero");
  property p_range; CODE_WR_EN_O |-> CODE_WR_ADDR_O < CODE_DEPTH; endproperty
  a_range: assert property (p_range) else $error("write past end");
  // Next code address a write must use; restarts whenever busy is low
  addr_t wr_expect;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I || !LOADER_LOAD_BUSY_O) wr_expect <= 12'h000;
    else if (CODE_WR_EN_O) wr_expect <= wr_expect + 12'h001;
  end
  property p_wr_order; CODE_WR_EN_O |-> CODE_WR_ADDR_O == wr_expect; endproperty
  a_wr_order: assert property (p_wr_order) else $error("write out of order");
  property p_busy_end;
    $fell(LOADER_LOAD_BUSY_O) |-> $past(CODE_WR_EN_O, 2) && $past(CODE_WR_ADDR_O, 2) == CODE_DEPTH - 1;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped before last write");
endmodule : code_memory_rom_loader_assertions
bind code_memory_rom_loader code_memory_rom_loader_assertions #(.CODE_DEPTH(CODE_DEPTH)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .LOADER_LOAD_BUSY_O(LOADER_LOAD_BUSY_O),
  .LOADER_ROM_READ_ENABLE_O(LOADER_ROM_READ_ENABLE_O), .LOADER_ROM_ADDR_O(LOADER_ROM_ADDR_O),
  .CODE_WR_EN_O(CODE_WR_EN_O), .CODE_WR_ADDR_O(CODE_WR_ADDR_O), .CODE_WR_READY_I(CODE_WR_READY_I));
`default_nettype wire

/* File: testbench/rom_model.sv */
// External ROM plus user logic that strobes each word in.
// Assumes the loader clock; slow_i widens the gap between words.
`timescale 1ns/1ps
`default_nettype none
module rom_model
  import loader_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rden_i,
  input  wire addr_t addr_i,
  input  wire logic  slow_i,
  output logic       ready_o,
  output word_t      word_o
);
  initial begin
    ready_o = 1'b0;
    word_o = 32'h0;
    forever begin
      @(negedge clk_i);
      if (rden_i) begin
        word_o = {20'hC0DE5, addr_i};
        ready_o = 1'b1;
        repeat (4) @(negedge clk_i);
        ready_o = 1'b0;
        // Word released: drive the inverse so a late sample cannot pass
        word_o = ~word_o;
        repeat (slow_i ? 20 : 4) @(negedge clk_i);
      end
    end
  end
endmodule : rom_model
`default_nettype wire

/* File: testbench/code_memory_rom_loader_tb_top.sv */
// Self-checking bench for the loader with a short code memory.
// Assumes rom_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module code_memory_rom_loader_tb_top
  import loader_pkg::*;
();
  localparam int DEPTH = 8;
  logic  clk, rst_b, active, wready, cready, slow, busy, rden, wr_en;
  word_t rom_word, wr_data;
  addr_t rom_addr, wr_addr;
  int    n_mismatch = 0;
  int    checks_done = 0;
  code_memory_rom_loader #(.CODE_DEPTH(DEPTH)) u_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .LOADER_LOAD_ACTIVE_I(active), .LOADER_WORD_READY_I(wready), .LOADER_ROM_WORD_IN_I(rom_word),
    .LOADER_LOAD_BUSY_O(busy), .LOADER_ROM_READ_ENABLE_O(rden), .LOADER_ROM_ADDR_O(rom_addr),
    .CODE_WR_EN_O(wr_en), .CODE_WR_ADDR_O(wr_addr), .CODE_WR_DATA_O(wr_data), .CODE_WR_READY_I(cready));
  rom_model u_rom (.clk_i(clk), .rden_i(rden), .addr_i(rom_addr), .slow_i(slow), .ready_o(wready),
    .word_o(rom_word));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Stalls the code memory for 30 cycles once stall_at words are in
  task automatic run_load(input logic slw, input int stall_at);
    int n, t, s;
    n = 0; t = 0; s = 0;
    slow = slw;
    active = 1'b1;
    while (busy !== 1'b1 && t < 50) begin @(negedge clk); t++; end
    check("rden", rden, 1);
    check("rom_addr", rom_addr, 0);
    while (n < DEPTH && t < 3000) begin
      @(negedge clk); t++;
      // Ready is set before the strobe is judged, so each counted pulse
      // is one that the memory really takes at the next rising edge
      if (n == stall_at && s < 30) begin cready = 1'b0; s++; end
      else cready = 1'b1;
      #1;
      if (wr_en === 1'b1) begin
        check("wr_addr", wr_addr, n);
        check("wr_data", wr_data, {20'hC0DE5, 12'(n)});
        check("busy", busy, 1);
        n++;
      end
    end
    check("words", n, DEPTH);
    t = 0;
    // PHY soft reset would only follow this wait
    while (busy !== 1'b0 && t < 100) begin @(negedge clk); t++; end
    check("busy_end", busy, 0);
    check("rden_end", rden, 0);
    active = 1'b0;
    repeat (40) @(negedge clk);
  endtask : run_load
  task automatic t_prompt; run_load(1'b0, -1); endtask : t_prompt
  task automatic t_stall; run_load(1'b1, 2); endtask : t_stall
  task automatic t_reset_mid;
    active = 1'b1;
    repeat (30) @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    check("rst_busy", busy, 0);
    check("rst_addr", rom_addr, 0);
    rst_b = 1'b1;
    active = 1'b0;
    repeat (40) @(negedge clk);
  endtask : t_reset_mid
  initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
  initial begin repeat (20000) @(posedge clk); n_mismatch++; report_and_stop(); end
  initial begin
    rst_b = 1'b0; active = 1'b0; cready = 1'b1; slow = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_prompt();
    t_stall();
    t_reset_mid();
    t_prompt();
    report_and_stop();
  end
endmodule : code_memory_rom_loader_tb_top
`default_nettype wire
